// ===== hdl/rfid_cfg_map.vh
// Register map, field positions, preset values and timing figures
// for the protocol configuration bank. Definitions only.
`ifndef RFID_CFG_MAP_VH
`define RFID_CFG_MAP_VH

// ********************************************************************
// Register offsets
// ********************************************************************
`define ADDR_W          6
`define PROTO_ADDR      6'h01
`define TXOPT_ADDR      6'h02
`define RXOPT_ADDR      6'h03
`define CAL_LO_ADDR     6'h04
`define CAL_HI_ADDR     6'h05

// ********************************************************************
// Preset values and writable-bit masks
// ********************************************************************
`define PROTO_RST       8'h06
`define TXOPT_RST       8'hf0
`define RXOPT_RST       8'h60
`define CAL_LO_RST      8'h35
`define CAL_HI_RST      8'h05
`define PROTO_MASK      8'hff
`define TXOPT_MASK      8'hf3
`define RXOPT_MASK      8'hf2
`define CAL_LO_MASK     8'hff
`define CAL_HI_MASK     8'h7f

// ********************************************************************
// Field positions
// ********************************************************************
`define CRC_BYP_BIT     7
`define RAW_SEL_BIT     6
`define PROT_RANGE      5:4
`define DEC_RANGE       3:2
`define TARI_RANGE      1:0
`define PW_RANGE        7:6
`define ONE_RANGE       5:4
`define SESS_RANGE      1:0
`define LF_RANGE        7:4
`define TREXT_BIT       1
`define MIX_LOW_BIT     6
`define IO_LOW_BIT      5
`define PD_ONLY_BIT     4
`define CAL_HI_RANGE    3:0

// ********************************************************************
// Field codes
// ********************************************************************
`define PROT_GEN2       2'h0
`define PROT_TYPEAB     2'h2
`define DEC_FM0         2'h0
`define DEC_M2          2'h1
`define DEC_M4          2'h2
`define DEC_M8          2'h3
`define TARI_6U25       2'h0
`define TARI_12U5       2'h1
`define TARI_25U        2'h2
`define TARI_UNDEF      2'h3
`define LF_40K          4'h0
`define LF_80K          4'h3
`define LF_160K         4'h6
`define LF_213K         4'h8
`define LF_256K         4'h9
`define LF_320K         4'hc
`define LF_640K         4'hf

// ********************************************************************
// Timing figures
// ********************************************************************
`define CLK_HZ          50000000
`define CLK_MHZ         50
`define TARI_6U25_NS    6250
`define TARI_12U5_NS    12500
`define TARI_25U_NS     25000
`define NS_PER_US_X     1000
`define PW_PCT_0        8'd27
`define PW_PCT_1        8'd35
`define PW_PCT_2        8'd44
`define PW_PCT_3        8'd50
`define ONE_PCT_0       8'd150
`define ONE_PCT_1       8'd166
`define ONE_PCT_2       8'd183
`define ONE_PCT_3       8'd200
`define PCT_DIV         19'd100
`define LF_40K_HZ       40000
`define LF_80K_HZ       80000
`define LF_160K_HZ      160000
`define LF_213K_HZ      213300
`define LF_256K_HZ      256000
`define LF_320K_HZ      320000
`define LF_640K_HZ      640000
`define TRCAL_STEP_NS   100
`define TRCAL_CYC_STEP  3'd5
`define TRCAL_MIN       12'd172
`define TRCAL_MAX       12'd2250

`endif

// ===== hdl/enable_sync.v
// Two-stage synchroniser for the chip enable pin.
// Assumes the pin is asynchronous to sys_clk; output is low in reset.
`timescale 1ns/10ps

module enable_sync (
    input  wire sys_clk,
    input  wire sys_rst,
    input  wire pin_in,
    output reg  level_out
);

    reg stage_one;

    // First stage feeds only the second
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_one <= 1'b0;
            level_out <= 1'b0;
        end else begin
            stage_one <= pin_in;
            level_out <= stage_one;
        end
    end

endmodule // enable_sync

// ===== hdl/io_pin_drive.v
// Output stage for the clock and auxiliary pins: push-pull or
// pull-down only. Assumes the board supplies a pull-up when open-drain.
`timescale 1ns/10ps

module io_pin_drive #(
    parameter N = 3
) (
    input  wire         sys_clk,
    input  wire         sys_rst,
    input  wire         pulldown_only,
    input  wire [N-1:0] level_in,
    output reg  [N-1:0] pin_out,
    output reg  [N-1:0] pin_oe
);

    genvar i;

    // ****************************************************************
    // One registered driver per pin
    // ****************************************************************
    generate
        for (i = 0; i < N; i = i + 1) begin : g_pin
            // Open-drain drives only the low level, releases for high
            always @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pin_out[i] <= 1'b0;
                    pin_oe[i]  <= 1'b0;
                end else if (pulldown_only) begin
                    pin_out[i] <= 1'b0;
                    pin_oe[i]  <= ~level_in[i];
                end else begin
                    pin_out[i] <= level_in[i];
                    pin_oe[i]  <= 1'b1;
                end
            end
        end
    endgenerate

endmodule // io_pin_drive

// ===== hdl/rfid_protocol_config_regs.v
// Protocol configuration register bank of a UHF reader: five host
// registers and the decoded settings they feed to coder, decoder, pins.
// Assumes a same-clock host register port and an asynchronous EN pin.
//
// What this block does
// - CRC bypass bit 1 skips check and keeps CRC bytes; interrupt still raised.
// - Raw select 0 routes decoder bit and clock; 1 routes subcarrier data.
// - Protocol code 00 selects Gen2; code 10 enables Type A/B direct decoder.
// - Decode code 00 FM0, 01 Miller 2, 10 Miller 4, 11 Miller 8.
// - Tari code 00 6.25us, 01 12.5us, 10 25us; 11 undefined.
// - Protocol register presets to 06 when EN low or power-on reset.
// - Pulse width codes give 0.27, 0.35, 0.44, 0.50 Tari.
// - Data-one codes give 1.50, 1.66, 1.83, 2.00 Tari.
// - Low two transmit option bits hold the Gen2 session value.
// - Transmit options register presets to F0 on EN low or reset.
// - Link frequency codes pick seven rates; register presets to 60.
// - TRext 0 short preamble, 1 long; short only with Miller 4/8.
// - Calibration time is 12 bits split over low and high registers.
// - Each calibration count is 0.1us; Gen2 range 17.2us to 225us.
// - Calibration low register presets to 35, giving 1333 counts.
// - Pull-down-only bit makes clock and auxiliary pins open-drain.
// - Mixer supply bit selects 4.8V clear, 3.7V set, as stored output.
`timescale 1ns/10ps
`include "rfid_cfg_map.vh"

module rfid_protocol_config_regs (
    input  wire                 sys_clk,
    input  wire                 sys_rst,
    input  wire                 chip_enable,
    input  wire [`ADDR_W-1:0]   reg_addr,
    input  wire [7:0]           reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [7:0]           reg_rdata,
    input  wire                 rx_frame_done,
    input  wire                 rx_crc_bad,
    output reg                  rx_done_irq,
    output reg                  rx_crc_error,
    output reg                  crc_check_en,
    output reg                  crc_strip_en,
    input  wire                 dec_bit_in,
    input  wire                 dec_clk_in,
    input  wire                 subcarrier_in,
    output reg                  direct_data_out,
    output reg                  direct_clk_out,
    output reg                  gen2_mode,
    output reg                  typeab_direct_mode,
    output reg  [3:0]           decode_onehot,
    output reg                  tari_valid,
    output reg  [10:0]          tari_cycles,
    output reg  [11:0]          tx_pw_cycles,
    output reg  [11:0]          tx_one_cycles,
    output reg  [1:0]           session,
    output reg                  lf_valid,
    output reg  [10:0]          lf_period_cycles,
    output reg                  long_preamble,
    output reg                  preamble_unsupported,
    output reg  [11:0]          trcal_count,
    output reg  [14:0]          trcal_cycles,
    output reg                  trcal_in_range,
    output reg                  mixer_supply_low,
    output reg                  low_io_voltage,
    input  wire                 system_clock_src,
    input  wire                 aux_a_src,
    input  wire                 aux_b_src,
    output wire                 system_clock_out,
    output wire                 system_clock_oe,
    output wire                 aux_output_a,
    output wire                 aux_output_a_oe,
    output wire                 aux_output_b,
    output wire                 aux_output_b_oe
);

    // ****************************************************************
    // Storage and helpers
    // ****************************************************************
    reg  [7:0]  protocol_select;
    reg  [7:0]  tx_pulse_options;
    reg  [7:0]  rx_link_options;
    reg  [7:0]  calibration_time_low;
    reg  [7:0]  calibration_time_high_misc;
    wire        en_level;
    wire        presetting;
    wire [11:0] next_trcal;
    wire [1:0]  dec_code;
    wire [10:0] tari_now;
    wire [2:0]  pin_out_bus;
    wire [2:0]  pin_oe_bus;

    // Tari in cycles, least time rounded up
    function [10:0] tari_cyc;
        input [1:0]  code;
        reg   [31:0] full;
        begin
            case (code)
                `TARI_6U25: full =
                    (`TARI_6U25_NS * `CLK_MHZ + `NS_PER_US_X - 1) / `NS_PER_US_X;
                `TARI_12U5: full =
                    (`TARI_12U5_NS * `CLK_MHZ + `NS_PER_US_X - 1) / `NS_PER_US_X;
                `TARI_25U:  full =
                    (`TARI_25U_NS * `CLK_MHZ + `NS_PER_US_X - 1) / `NS_PER_US_X;
                default:    full = 32'h00000000;
            endcase
            tari_cyc = full[10:0];
        end
    endfunction

    // Fraction of a Tari, in hundredths
    function [11:0] scale_pct;
        input [10:0] t;
        input [7:0]  pct;
        reg   [18:0] prod;
        reg   [18:0] quot;
        begin
            prod      = t * pct;
            quot      = prod / `PCT_DIV;
            scale_pct = quot[11:0];
        end
    endfunction

    // Link frequency period in cycles; zero marks an unlisted code
    function [10:0] lf_cyc;
        input [3:0]  code;
        reg   [31:0] full;
        begin
            case (code)
                `LF_40K:  full = `CLK_HZ / `LF_40K_HZ;
                `LF_80K:  full = `CLK_HZ / `LF_80K_HZ;
                `LF_160K: full = `CLK_HZ / `LF_160K_HZ;
                `LF_213K: full = `CLK_HZ / `LF_213K_HZ;
                `LF_256K: full = `CLK_HZ / `LF_256K_HZ;
                `LF_320K: full = `CLK_HZ / `LF_320K_HZ;
                `LF_640K: full = `CLK_HZ / `LF_640K_HZ;
                default:  full = 32'h00000000;
            endcase
            lf_cyc = full[10:0];
        end
    endfunction

    // ****************************************************************
    // Enable pin and preset
    // ****************************************************************
    enable_sync u_en_sync (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .pin_in    (chip_enable),
        .level_out (en_level)
    );

    // EN low holds every register at its preset value
    assign presetting = ~en_level;

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Reserved bits are never stored so they always read as zero
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            protocol_select            <= `PROTO_RST;
            tx_pulse_options           <= `TXOPT_RST;
            rx_link_options            <= `RXOPT_RST;
            calibration_time_low       <= `CAL_LO_RST;
            calibration_time_high_misc <= `CAL_HI_RST;
        end else if (presetting) begin
            protocol_select            <= `PROTO_RST;
            tx_pulse_options           <= `TXOPT_RST;
            rx_link_options            <= `RXOPT_RST;
            calibration_time_low       <= `CAL_LO_RST;
            calibration_time_high_misc <= `CAL_HI_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `PROTO_ADDR:  protocol_select  <= reg_wdata & `PROTO_MASK;
                `TXOPT_ADDR:  tx_pulse_options <= reg_wdata & `TXOPT_MASK;
                `RXOPT_ADDR:  rx_link_options  <= reg_wdata & `RXOPT_MASK;
                `CAL_LO_ADDR: calibration_time_low <= reg_wdata & `CAL_LO_MASK;
                `CAL_HI_ADDR: calibration_time_high_misc <= reg_wdata & `CAL_HI_MASK;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Data one cycle after the read strobe; unmapped reads give zero
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PROTO_ADDR:  reg_rdata <= protocol_select;
                `TXOPT_ADDR:  reg_rdata <= tx_pulse_options;
                `RXOPT_ADDR:  reg_rdata <= rx_link_options;
                `CAL_LO_ADDR: reg_rdata <= calibration_time_low;
                `CAL_HI_ADDR: reg_rdata <= calibration_time_high_misc;
                default:      reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Decoded settings
    // ****************************************************************
    assign next_trcal = {calibration_time_high_misc[`CAL_HI_RANGE],
                         calibration_time_low};
    assign dec_code   = protocol_select[`DEC_RANGE];
    assign tari_now   = tari_cyc(protocol_select[`TARI_RANGE]);

    // All settings registered so consumers see glitch-free levels
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            crc_check_en         <= 1'b1;
            crc_strip_en         <= 1'b1;
            gen2_mode            <= 1'b1;
            typeab_direct_mode   <= 1'b0;
            decode_onehot        <= 4'h0;
            tari_valid           <= 1'b0;
            tari_cycles          <= 11'h000;
            tx_pw_cycles         <= 12'h000;
            tx_one_cycles        <= 12'h000;
            session              <= 2'h0;
            lf_valid             <= 1'b0;
            lf_period_cycles     <= 11'h000;
            long_preamble        <= 1'b0;
            preamble_unsupported <= 1'b0;
            trcal_count          <= 12'h000;
            trcal_cycles         <= 15'h0000;
            trcal_in_range       <= 1'b0;
            mixer_supply_low     <= 1'b0;
            low_io_voltage       <= 1'b0;
        end else begin
            crc_check_en <= ~protocol_select[`CRC_BYP_BIT];
            crc_strip_en <= ~protocol_select[`CRC_BYP_BIT];
            gen2_mode <= (protocol_select[`PROT_RANGE] == `PROT_GEN2);
            typeab_direct_mode <=
                (protocol_select[`PROT_RANGE] == `PROT_TYPEAB);
            decode_onehot <= 4'h1 << dec_code;
            tari_valid  <= (protocol_select[`TARI_RANGE] != `TARI_UNDEF);
            tari_cycles <= tari_now;
            // Pulse width and data-one scale with the current Tari
            case (tx_pulse_options[`PW_RANGE])
                2'h0:    tx_pw_cycles <= scale_pct(tari_now, `PW_PCT_0);
                2'h1:    tx_pw_cycles <= scale_pct(tari_now, `PW_PCT_1);
                2'h2:    tx_pw_cycles <= scale_pct(tari_now, `PW_PCT_2);
                default: tx_pw_cycles <= scale_pct(tari_now, `PW_PCT_3);
            endcase
            case (tx_pulse_options[`ONE_RANGE])
                2'h0:    tx_one_cycles <= scale_pct(tari_now, `ONE_PCT_0);
                2'h1:    tx_one_cycles <= scale_pct(tari_now, `ONE_PCT_1);
                2'h2:    tx_one_cycles <= scale_pct(tari_now, `ONE_PCT_2);
                default: tx_one_cycles <= scale_pct(tari_now, `ONE_PCT_3);
            endcase
            session <= tx_pulse_options[`SESS_RANGE];
            lf_period_cycles <= lf_cyc(rx_link_options[`LF_RANGE]);
            lf_valid <= (lf_cyc(rx_link_options[`LF_RANGE]) != 11'h000);
            long_preamble <= rx_link_options[`TREXT_BIT];
            // Short preamble only legal with Miller 4 or Miller 8
            preamble_unsupported <= ~rx_link_options[`TREXT_BIT] &
                ((dec_code == `DEC_FM0) | (dec_code == `DEC_M2));
            trcal_count  <= next_trcal;
            trcal_cycles <= next_trcal * `TRCAL_CYC_STEP;
            trcal_in_range <= (next_trcal >= `TRCAL_MIN) &
                              (next_trcal <= `TRCAL_MAX);
            mixer_supply_low <= calibration_time_high_misc[`MIX_LOW_BIT];
            // Drive strength is analog; the bit is only passed on
            low_io_voltage <= calibration_time_high_misc[`IO_LOW_BIT];
        end
    end

    // ****************************************************************
    // Receive events
    // ****************************************************************
    // Frame-end interrupt in both CRC modes; error only when checking
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_done_irq  <= 1'b0;
            rx_crc_error <= 1'b0;
        end else begin
            rx_done_irq  <= rx_frame_done;
            rx_crc_error <= rx_frame_done & rx_crc_bad &
                            ~protocol_select[`CRC_BYP_BIT];
        end
    end

    // ****************************************************************
    // Direct mode output routing
    // ****************************************************************
    // Subcarrier mode reuses the data pin; clock held low there
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            direct_data_out <= 1'b0;
            direct_clk_out  <= 1'b0;
        end else if (protocol_select[`RAW_SEL_BIT]) begin
            direct_data_out <= subcarrier_in;
            direct_clk_out  <= 1'b0;
        end else begin
            direct_data_out <= dec_bit_in;
            direct_clk_out  <= dec_clk_in;
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    io_pin_drive #(
        .N (3)
    ) u_pins (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .pulldown_only (calibration_time_high_misc[`PD_ONLY_BIT]),
        .level_in      ({aux_b_src, aux_a_src, system_clock_src}),
        .pin_out       (pin_out_bus),
        .pin_oe        (pin_oe_bus)
    );

    assign system_clock_out = pin_out_bus[0];
    assign system_clock_oe  = pin_oe_bus[0];
    assign aux_output_a     = pin_out_bus[1];
    assign aux_output_a_oe  = pin_oe_bus[1];
    assign aux_output_b     = pin_out_bus[2];
    assign aux_output_b_oe  = pin_oe_bus[2];

endmodule // rfid_protocol_config_regs

// ===== testbench/rfid_cfg_monitor.sv
// Port assertions for the protocol configuration bank.
// Assumes one sys_clk domain; attached to the bank by bind.
`timescale 1ns/10ps
module rfid_cfg_monitor (
    input wire        sys_clk, sys_rst, rx_frame_done, rx_crc_bad, rx_done_irq,
    input wire        rx_crc_error, crc_check_en, dec_clk_in, direct_clk_out,
    input wire        gen2_mode, typeab_direct_mode, tari_valid, lf_valid,
    input wire        long_preamble, preamble_unsupported,
    input wire [3:0]  decode_onehot,
    input wire [10:0] tari_cycles, lf_period_cycles
);
// ********
// Checks
// ********
// Single domain, so clock and reset are named once
default clocking dclk @(posedge sys_clk);
endclocking
default disable iff (sys_rst);
property p_irq; rx_done_irq == $past(rx_frame_done); endproperty
a_irq: assert property (p_irq) else $error("frame interrupt wrong");
property p_crc; rx_crc_error == ($past(rx_frame_done && rx_crc_bad) && crc_check_en); endproperty
a_crc: assert property (p_crc) else $error("crc error flag wrong");
property p_direct; direct_clk_out |-> $past(dec_clk_in); endproperty
a_direct: assert property (p_direct) else $error("direct clock wrong");
property p_mode; !(gen2_mode && typeab_direct_mode); endproperty
a_mode: assert property (p_mode) else $error("two protocols at once");
// Skips the first edge after reset, where settings still show zero
property p_onehot; !$past(sys_rst) |-> $onehot(decode_onehot); endproperty
a_onehot: assert property (p_onehot) else $error("decoder select wrong");
property p_tari; tari_valid == (tari_cycles != 11'h000); endproperty
a_tari: assert property (p_tari) else $error("tari valid wrong");
property p_lf; lf_valid == (lf_period_cycles != 11'h000); endproperty
a_lf: assert property (p_lf) else $error("link valid wrong");
property p_pre; preamble_unsupported == (!long_preamble && |decode_onehot[1:0]); endproperty
a_pre: assert property (p_pre) else $error("preamble flag wrong");
endmodule // rfid_cfg_monitor

bind rfid_protocol_config_regs rfid_cfg_monitor u_mon (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .rx_frame_done(rx_frame_done),
    .rx_crc_bad(rx_crc_bad), .rx_done_irq(rx_done_irq), .rx_crc_error(rx_crc_error),
    .crc_check_en(crc_check_en), .dec_clk_in(dec_clk_in), .direct_clk_out(direct_clk_out),
    .gen2_mode(gen2_mode), .typeab_direct_mode(typeab_direct_mode),
    .tari_valid(tari_valid), .lf_valid(lf_valid), .long_preamble(long_preamble),
    .preamble_unsupported(preamble_unsupported), .decode_onehot(decode_onehot),
    .tari_cycles(tari_cycles), .lf_period_cycles(lf_period_cycles));

// ===== testbench/rfid_host_model.sv
// Host controller model on the strobed register port.
// Assumes callers wait for reset release before any access.
`timescale 1ns/10ps
module rfid_host_model (
    input  wire       sys_clk,
    input  wire [7:0] reg_rdata,
    output reg  [5:0] reg_addr = 6'h00,
    output reg  [7:0] reg_wdata = 8'h00,
    output reg        reg_wr = 1'b0,
    output reg        reg_rd = 1'b0
);
// ********
// Accesses
// ********
// Data inverted after release so a stale value never looks held
task write_reg(input [5:0] a, input [7:0] d);
    begin
        @(posedge sys_clk) #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk) #1 reg_wr = 1'b0;
        reg_wdata = ~d;
    end
endtask
task read_reg(input [5:0] a, output [7:0] d);
    begin
        @(posedge sys_clk) #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk) #1 reg_rd = 1'b0;
        d = reg_rdata;
    end
endtask
endmodule // rfid_host_model

// ===== testbench/rfid_protocol_config_regs_test.sv
// Self-checking bench for the protocol configuration bank.
// Assumes the host model owns the register port; all else is driven here.
`timescale 1ns/10ps
module rfid_protocol_config_regs_test;
logic        sys_clk, sys_rst, chip_enable, rx_frame_done, rx_crc_bad, reg_wr, reg_rd;
logic        dec_bit_in, dec_clk_in, subcarrier_in, system_clock_src, aux_a_src, aux_b_src;
logic        rx_done_irq, rx_crc_error, crc_check_en, crc_strip_en, direct_data_out;
logic        direct_clk_out, gen2_mode, typeab_direct_mode, tari_valid, lf_valid;
logic        long_preamble, preamble_unsupported, trcal_in_range, mixer_supply_low;
logic        low_io_voltage;
logic [1:0]  session;
logic [3:0]  decode_onehot;
logic [5:0]  reg_addr;
logic [7:0]  reg_wdata, reg_rdata, rd;
logic [10:0] tari_cycles, lf_period_cycles;
logic [11:0] tx_pw_cycles, tx_one_cycles, trcal_count;
logic [14:0] trcal_cycles;
wire         system_clock_out, system_clock_oe, aux_output_a, aux_output_a_oe;
wire         aux_output_b, aux_output_b_oe;
int          mismatches = 0, tests_run = 0;
typedef struct { logic [5:0] a; logic [7:0] d; logic [7:0] r; } row_t;
// Write, then the masked read-back; unmapped places last
row_t rows [8] = '{'{6'h01, 8'h16, 8'h16}, '{6'h02, 8'hff, 8'hf3}, '{6'h03, 8'hff, 8'hf2},
    '{6'h04, 8'ha5, 8'ha5}, '{6'h05, 8'hff, 8'h7f}, '{6'h00, 8'h5a, 8'h00},
    '{6'h06, 8'h5a, 8'h00}, '{6'h3f, 8'h5a, 8'h00}};
logic [7:0]  presets [5] = '{8'h06, 8'hf0, 8'h60, 8'h35, 8'h05};
int          tari_cyc [4] = '{313, 625, 1250, 0};
int          pw_pct [4] = '{27, 35, 44, 50};
int          one_pct [4] = '{150, 166, 183, 200};
int          lf_code [7] = '{0, 3, 6, 8, 9, 12, 15};
int          lf_hz [7] = '{40000, 80000, 160000, 213300, 256000, 320000, 640000};
rfid_protocol_config_regs u_dut (.*);
rfid_host_model u_host (.*);
// ********
// Helpers
// ********
always #10 sys_clk = ~sys_clk;
task check(input string what, input [15:0] exp, input [15:0] got);
    tests_run++;
    if (got !== exp) begin
        mismatches++;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
endtask
// Derived settings land one edge after the register
task put(input [5:0] a, input [7:0] d);
    u_host.write_reg(a, d);
    @(posedge sys_clk) #1;
endtask
task frame(input logic bad, input logic err);
    @(posedge sys_clk) #1 rx_frame_done = 1'b1;
    rx_crc_bad = bad;
    @(posedge sys_clk) #1 rx_frame_done = 1'b0;
    check("irq", 1'b1, rx_done_irq);
    check("crc_err", err, rx_crc_error);
endtask
task print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
// Limit is far beyond the roughly 135 cycles the run needs
initial begin
    #400000;
    mismatches++;
    print_verdict;
end
// ********
// Tests
// ********
initial begin
    {sys_clk, sys_rst, chip_enable, system_clock_src} = 4'h7;
    {rx_frame_done, rx_crc_bad, dec_bit_in, dec_clk_in, subcarrier_in} = 5'h00;
    {aux_a_src, aux_b_src} = 2'h0;
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    foreach (presets[i]) begin
        u_host.read_reg(6'(i + 1), rd);
        check("preset", presets[i], rd);
    end
    foreach (rows[k]) begin
        put(rows[k].a, rows[k].d);
        u_host.read_reg(rows[k].a, rd);
        check("readback", rows[k].r, rd);
    end
    check("trcal", 16'hfa5, trcal_count);
    check("trcal_cyc", 16'hfa5 * 5, trcal_cycles);
    check("in_range", 1'b0, trcal_in_range);
    check("session", 2'h3, session);
    check("misc", 2'h3, {mixer_supply_low, low_io_voltage});
    check("pins", 6'h05, {system_clock_out, system_clock_oe, aux_output_a, aux_output_a_oe,
        aux_output_b, aux_output_b_oe});
    put(6'h05, 8'h05);
    check("pins", 6'h35, {system_clock_out, system_clock_oe, aux_output_a, aux_output_a_oe,
        aux_output_b, aux_output_b_oe});
    check("in_range", 1'b1, trcal_in_range);
    for (int c = 0; c < 4; c++) begin
        put(6'h01, 8'(c * 5));
        check("decode", 16'h1 << c, decode_onehot);
        check("tari", tari_cyc[c], tari_cycles);
        check("tari_ok", c != 3, tari_valid);
    end
    put(6'h01, 8'h06);
    for (int c = 0; c < 4; c++) begin
        put(6'h02, 8'(c * 80));
        check("pw", 1250 * pw_pct[c] / 100, tx_pw_cycles);
        check("one", 1250 * one_pct[c] / 100, tx_one_cycles);
    end
    for (int c = 0; c < 7; c++) begin
        put(6'h03, 8'(lf_code[c] * 16));
        check("lf", 50000000 / lf_hz[c], lf_period_cycles);
        check("lf_ok", 1'b1, lf_valid);
    end
    put(6'h03, 8'h10);
    check("lf", 16'h0, lf_period_cycles);
    check("lf_ok", 1'b0, lf_valid);
    check("preamble", 2'h1, {long_preamble, preamble_unsupported});
    check("proto", 2'h2, {gen2_mode, typeab_direct_mode});
    put(6'h01, 8'h26);
    check("proto", 2'h1, {gen2_mode, typeab_direct_mode});
    frame(1'b1, 1'b1);
    put(6'h01, 8'h86);
    check("crc_en", 2'h0, {crc_check_en, crc_strip_en});
    frame(1'b1, 1'b0);
    {dec_bit_in, dec_clk_in} = 2'h3;
    @(posedge sys_clk) #1;
    check("direct", 2'h3, {direct_data_out, direct_clk_out});
    put(6'h01, 8'hc6);
    check("raw", 2'h0, {direct_data_out, direct_clk_out});
    chip_enable = 1'b0;
    repeat (3) @(posedge sys_clk);
    put(6'h02, 8'h00);
    u_host.read_reg(6'h02, rd);
    check("en_low", 8'hf0, rd);
    u_host.read_reg(6'h01, rd);
    check("en_low", 8'h06, rd);
    print_verdict;
end
endmodule // rfid_protocol_config_regs_test
